// ===== agcf_pkg.sv
// Shared constants and types of the gain and fault controller
package agcf_pkg;

    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] IDX_STATUS  = 8'h01;
    localparam logic [7:0] OFF_STATUS  = 8'(IDX_STATUS * 4);
    localparam logic [7:0] OFF_MASK    = 8'h08;
    localparam logic [7:0] OFF_ATTACK  = 8'h0C;
    localparam logic [7:0] OFF_RELEASE = 8'h10;
    localparam logic [7:0] OFF_HOLD    = 8'h14;
    localparam logic [7:0] OFF_FIXED   = 8'h18;
    localparam logic [7:0] OFF_MAXGAIN = 8'h1C;
    localparam logic [7:0] OFF_LIMIT   = 8'h20;
    localparam logic [7:0] OFF_GAIN    = 8'h24;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned CTRL_SHUT   = 0;
    localparam int unsigned CTRL_OFF_L  = 1;
    localparam int unsigned CTRL_OFF_R  = 2;
    localparam int unsigned CTRL_AGC_EN = 3;
    localparam int unsigned CTRL_COMP   = 4;
    localparam int unsigned CTRL_RATIO  = 5;
    localparam int unsigned STAT_DOWN   = 0;
    localparam int unsigned STAT_UP     = 1;
    localparam int unsigned STAT_FAULT  = 3;
    localparam logic [7:0]  STAT_USED   = 8'h0B;
    localparam int unsigned LIMIT_W     = 5;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] CTRL_RST    = 8'h18;
    localparam logic [7:0] MASK_RST    = 8'h00;
    localparam logic [7:0] ATTACK_RST  = 8'h05;
    localparam logic [7:0] RELEASE_RST = 8'h0B;
    localparam logic [7:0] HOLD_RST    = 8'h10;
    localparam logic [7:0] FIXED_RST   = 8'h06;
    localparam logic [7:0] MAXGAIN_RST = 8'h1E;
    localparam logic [7:0] LIMIT_RST   = 8'h1A;

    // ****************************************
    // Gain limits in dB, gain kept in half dB
    // ****************************************
    localparam logic signed [7:0] DB_MIN_COMP   = -8'sh1C;
    localparam logic signed [7:0] DB_MIN_NOCOMP = 8'sh00;
    localparam logic signed [7:0] DB_MAX        = 8'sh1E;
    localparam logic signed [7:0] HALF_STEP     = 8'sh01;

    // ****************************************
    // Timebase
    // ****************************************
    localparam int unsigned CLK_NS  = 10;
    localparam int unsigned TICK_NS = 100000;
    localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PIN_N   = 5;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_SHUT  = 3'b001,
        ST_FIXED = 3'b010,
        ST_AGC   = 3'b100
    } agcf_state_t;

    typedef struct packed {
        logic shutdown_n_pin;
        logic short_det;
        logic over_limit;
        logic under_target;
        logic under_gate;
    } agcf_pins_t;

    typedef struct packed {
        logic [1:0] ratio;
        logic       comp_en;
        logic       agc_en;
        logic       off_r;
        logic       off_l;
        logic       software_shutdown_bit;
    } agcf_ctrl_t;

endpackage

// ===== agcf_sync.sv
// Three-stage pin synchroniser with agreement filter
module agcf_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] dout_nxt;

    // ****************************************
    // Per bit chain, output follows agreed level
    // ****************************************
    assign dout_nxt = (s2_r & s3_r) | (dout & (s2_r | s3_r));

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            dout <= {W{1'b0}};
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= dout_nxt;
        end
    end

endmodule

// ===== agcf_ivl.sv
// Minimum interval timer counted in timebase ticks
module agcf_ivl (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic       clr,
    input  wire logic [7:0] limit,
    output logic            done
);

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       sat;

    // Saturating tick count since last clear
    assign sat     = (cnt_r == 8'hFF);
    assign cnt_nxt = clr ? 8'h00 : ((tick && !sat) ? cnt_r + 8'h01 : cnt_r);
    assign done    = (cnt_r >= limit);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= 8'hFF;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

// ===== agcf_top.sv
// Gain control and short fault control with APB registers
//
// Behaviour
// - short fault forces reduced duty cycle mode
// - only shutdown pin or bit ends it
// - short sets fault flag, status bit 3
// - fault flag clears only by host write
// - each channel has own shutdown control
// - attack time spaces gain decrements
// - release time spaces gain increments
// - hold time before first increment after fall
// - below noise gate, gain frozen
// - fixed gain at start and AGC off
// - gain never raised above maximum gain
// - decrement gain while output over limiter
// - every adjustment is one half dB
// - decrement after attack, then restart timers
// - fixed gain range depends on compression
// - steady amplitude leaves gain unchanged
module agcf_top #(
    parameter int unsigned TICK_CYC = agcf_pkg::TICK_CYC
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SHUTDOWN_N_PIN,
    input  wire logic        SHORT_DET,
    input  wire logic        ENV_OVER_LIMIT,
    input  wire logic        ENV_UNDER_TARGET,
    input  wire logic        ENV_UNDER_GATE,
    output logic      [7:0]  GAIN_HALF_DB,
    output logic      [4:0]  LIMIT_LEVEL,
    output logic      [1:0]  COMP_RATIO,
    output logic             LOW_DUTY,
    output logic      [1:0]  CH_ENABLE,
    output logic             IRQ
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic signed [7:0] clamp(
        input logic signed [7:0] v,
        input logic signed [7:0] lo,
        input logic signed [7:0] hi
    );
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    agcf_pkg::agcf_pins_t  pins_raw;
    agcf_pkg::agcf_pins_t  pins;
    agcf_pkg::agcf_ctrl_t  ctrl;
    agcf_pkg::agcf_state_t state_r;
    agcf_pkg::agcf_state_t state_nxt;

    logic [7:0]         ctrl_r;
    logic [7:0]         stat_r;
    logic [7:0]         stat_nxt;
    logic [7:0]         mask_r;
    logic [7:0]         attack_r;
    logic [7:0]         release_r;
    logic [7:0]         hold_r;
    logic [7:0]         fixed_r;
    logic [7:0]         maxg_r;
    logic [7:0]         limit_r;
    logic signed [7:0]  gain_r;
    logic signed [7:0]  gain_nxt;
    logic [31:0]        prdata_nxt;
    logic               low_duty_r;
    logic [1:0]         ch_en_r;
    logic [1:0]         ch_en_nxt;
    logic [13:0]        div_r;
    logic               tick;

    logic               setup;
    logic               wr;
    logic               mapped;
    logic [7:0]         wbyte;
    logic [7:0]         rd_mux;
    logic [7:0]         clr_mask;
    logic [7:0]         ev;
    logic               dev_off;
    logic               in_agc;
    logic signed [7:0]  min_db;
    logic signed [7:0]  fixed_hd;
    logic signed [7:0]  max_hd;
    logic signed [7:0]  floor_hd;
    logic               attack_done;
    logic               release_done;
    logic               hold_done;
    logic               dec_go;
    logic               inc_go;
    logic               step;
    logic               hold_clr;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    assign pins_raw = '{shutdown_n_pin: SHUTDOWN_N_PIN, short_det: SHORT_DET,
                        over_limit: ENV_OVER_LIMIT,
                        under_target: ENV_UNDER_TARGET,
                        under_gate: ENV_UNDER_GATE};

    agcf_sync #(
        .W (agcf_pkg::PIN_N)
    ) u_sync (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .din   (pins_raw),
        .dout  (pins)
    );

    // ****************************************
    // APB decode
    // ****************************************
    assign setup   = PSEL && !PENABLE;
    assign wr      = PSEL && PENABLE && PWRITE && mapped;
    assign wbyte   = PWDATA[7:0];
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign mapped  = hit(PADDR, agcf_pkg::OFF_CTRL)
                  || hit(PADDR, agcf_pkg::OFF_STATUS)
                  || hit(PADDR, agcf_pkg::OFF_MASK)
                  || hit(PADDR, agcf_pkg::OFF_ATTACK)
                  || hit(PADDR, agcf_pkg::OFF_RELEASE)
                  || hit(PADDR, agcf_pkg::OFF_HOLD)
                  || hit(PADDR, agcf_pkg::OFF_FIXED)
                  || hit(PADDR, agcf_pkg::OFF_MAXGAIN)
                  || hit(PADDR, agcf_pkg::OFF_LIMIT)
                  || hit(PADDR, agcf_pkg::OFF_GAIN);

    assign rd_mux =
        hit(PADDR, agcf_pkg::OFF_CTRL)    ? ctrl_r :
        hit(PADDR, agcf_pkg::OFF_STATUS)  ? stat_r :
        hit(PADDR, agcf_pkg::OFF_MASK)    ? mask_r :
        hit(PADDR, agcf_pkg::OFF_ATTACK)  ? attack_r :
        hit(PADDR, agcf_pkg::OFF_RELEASE) ? release_r :
        hit(PADDR, agcf_pkg::OFF_HOLD)    ? hold_r :
        hit(PADDR, agcf_pkg::OFF_FIXED)   ? fixed_r :
        hit(PADDR, agcf_pkg::OFF_MAXGAIN) ? maxg_r :
        hit(PADDR, agcf_pkg::OFF_LIMIT)   ? limit_r :
        hit(PADDR, agcf_pkg::OFF_GAIN)    ? gain_r : 8'h00;

    assign prdata_nxt = (setup && !PWRITE) ? {24'h000000, rd_mux} : PRDATA;

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge REF_CLK)
    begin
        if (!RESETN)
        begin
            ctrl_r    <= agcf_pkg::CTRL_RST;
            mask_r    <= agcf_pkg::MASK_RST;
            attack_r  <= agcf_pkg::ATTACK_RST;
            release_r <= agcf_pkg::RELEASE_RST;
            hold_r    <= agcf_pkg::HOLD_RST;
            fixed_r   <= agcf_pkg::FIXED_RST;
            maxg_r    <= agcf_pkg::MAXGAIN_RST;
            limit_r   <= agcf_pkg::LIMIT_RST;
            PRDATA    <= 32'h00000000;
        end
        else
        begin
            if (wr && hit(PADDR, agcf_pkg::OFF_CTRL))    ctrl_r    <= wbyte;
            if (wr && hit(PADDR, agcf_pkg::OFF_MASK))    mask_r    <= wbyte;
            if (wr && hit(PADDR, agcf_pkg::OFF_ATTACK))  attack_r  <= wbyte;
            if (wr && hit(PADDR, agcf_pkg::OFF_RELEASE)) release_r <= wbyte;
            if (wr && hit(PADDR, agcf_pkg::OFF_HOLD))    hold_r    <= wbyte;
            if (wr && hit(PADDR, agcf_pkg::OFF_FIXED))   fixed_r   <= wbyte;
            if (wr && hit(PADDR, agcf_pkg::OFF_MAXGAIN)) maxg_r    <= wbyte;
            if (wr && hit(PADDR, agcf_pkg::OFF_LIMIT))   limit_r   <= wbyte;
            PRDATA <= prdata_nxt;
        end
    end

    assign ctrl = agcf_pkg::agcf_ctrl_t'(ctrl_r[6:0]);

    // ****************************************
    // Status, fault flag and interrupt
    // ****************************************
    assign ev = (8'(pins.short_det) << agcf_pkg::STAT_FAULT)
              | (8'(dec_go) << agcf_pkg::STAT_DOWN)
              | (8'(inc_go) << agcf_pkg::STAT_UP);
    assign clr_mask = (wr && hit(PADDR, agcf_pkg::OFF_STATUS)) ? wbyte : 8'h00;
    // Write one clears, a new event in the same cycle wins
    assign stat_nxt = (stat_r & ~clr_mask | ev) & agcf_pkg::STAT_USED;
    assign IRQ = |(stat_r & mask_r);

    always_ff @(posedge REF_CLK)
    begin
        if (!RESETN)
        begin
            stat_r <= 8'h00;
        end
        else
        begin
            stat_r <= stat_nxt;
        end
    end

    // ****************************************
    // Shutdown and reduced duty cycle
    // ****************************************
    assign dev_off   = !pins.shutdown_n_pin || ctrl.software_shutdown_bit;
    assign ch_en_nxt = {2{!dev_off}} & ~{ctrl.off_r, ctrl.off_l};

    always_ff @(posedge REF_CLK)
    begin
        if (!RESETN)
        begin
            low_duty_r <= 1'b0;
            ch_en_r    <= 2'b00;
        end
        else
        begin
            ch_en_r <= ch_en_nxt;
            if (dev_off)
            begin
                low_duty_r <= 1'b0;
            end
            else if (pins.short_det)
            begin
                low_duty_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // Timebase tick
    // ****************************************
    assign tick = (div_r == 14'(TICK_CYC - 1));

    always_ff @(posedge REF_CLK)
    begin
        if (!RESETN || tick)
        begin
            div_r <= 14'h0000;
        end
        else
        begin
            div_r <= div_r + 14'h0001;
        end
    end

    // ****************************************
    // Gain limits
    // ****************************************
    assign min_db   = ctrl.comp_en ? agcf_pkg::DB_MIN_COMP
                                   : agcf_pkg::DB_MIN_NOCOMP;
    assign fixed_hd = clamp(fixed_r, min_db, agcf_pkg::DB_MAX) <<< 1;
    assign max_hd   = clamp(maxg_r, min_db, agcf_pkg::DB_MAX) <<< 1;
    assign floor_hd = agcf_pkg::DB_MIN_COMP <<< 1;

    // ****************************************
    // Interval timers
    // ****************************************
    assign in_agc   = (state_r == agcf_pkg::ST_AGC) && !dev_off && ctrl.agc_en;
    assign step     = dec_go || inc_go;
    assign hold_clr = !in_agc || pins.over_limit || !pins.under_target;

    agcf_ivl u_attack (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .tick  (tick),
        .clr   (step || !in_agc),
        .limit (attack_r),
        .done  (attack_done)
    );

    agcf_ivl u_release (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .tick  (tick),
        .clr   (step || !in_agc),
        .limit (release_r),
        .done  (release_done)
    );

    agcf_ivl u_hold (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .tick  (tick),
        .clr   (hold_clr),
        .limit (hold_r),
        .done  (hold_done)
    );

    // ****************************************
    // Step decisions
    // ****************************************
    assign dec_go = in_agc && !pins.under_gate
                 && pins.over_limit && attack_done
                 && (gain_r > floor_hd);
    assign inc_go = in_agc && !pins.under_gate && !dec_go
                 && !pins.over_limit && pins.under_target
                 && hold_done && release_done
                 && (gain_r < max_hd);

    // ****************************************
    // Gain state machine
    // ****************************************
    always_comb
    begin
        state_nxt = state_r;
        gain_nxt  = gain_r;
        unique case (state_r)
            agcf_pkg::ST_SHUT:
            begin
                gain_nxt = fixed_hd;
                if (!dev_off)
                begin
                    state_nxt = ctrl.agc_en ? agcf_pkg::ST_AGC
                                            : agcf_pkg::ST_FIXED;
                end
            end
            agcf_pkg::ST_FIXED:
            begin
                gain_nxt = fixed_hd;
                if (dev_off)
                begin
                    state_nxt = agcf_pkg::ST_SHUT;
                end
                else if (ctrl.agc_en)
                begin
                    state_nxt = agcf_pkg::ST_AGC;
                end
            end
            agcf_pkg::ST_AGC:
            begin
                if (dev_off)
                begin
                    state_nxt = agcf_pkg::ST_SHUT;
                end
                else if (!ctrl.agc_en)
                begin
                    state_nxt = agcf_pkg::ST_FIXED;
                end
                else if (dec_go)
                begin
                    gain_nxt = gain_r - agcf_pkg::HALF_STEP;
                end
                else if (inc_go)
                begin
                    gain_nxt = gain_r + agcf_pkg::HALF_STEP;
                end
            end
            default:
            begin
                state_nxt = agcf_pkg::ST_SHUT;
            end
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RESETN)
        begin
            state_r <= agcf_pkg::ST_SHUT;
            gain_r  <= 8'sh00;
        end
        else
        begin
            state_r <= state_nxt;
            gain_r  <= gain_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign GAIN_HALF_DB = gain_r;
    assign LIMIT_LEVEL  = limit_r[agcf_pkg::LIMIT_W-1:0];
    assign COMP_RATIO   = ctrl.ratio;
    assign LOW_DUTY     = low_duty_r;
    assign CH_ENABLE    = ch_en_r;

endmodule

// ===== agcf_monitor.sv
// Port checker of the gain and fault controller
module agcf_monitor #(
    parameter int unsigned TICK_CYC = 4
) (
    input wire logic       REF_CLK,
    input wire logic       RESETN,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic       PWRITE,
    input wire logic       SHUTDOWN_N_PIN,
    input wire logic       SHORT_DET,
    input wire logic       ENV_OVER_LIMIT,
    input wire logic       ENV_UNDER_TARGET,
    input wire logic       ENV_UNDER_GATE,
    input wire logic [7:0] GAIN_HALF_DB,
    input wire logic       LOW_DUTY,
    input wire logic [1:0] CH_ENABLE,
    input wire logic       IRQ
);
    // ****************************************
    // Event age counters
    // ****************************************
    logic [7:0] wr_ago, sd_ago, sd_lo, gate_n, over_n, dgap, igap, gprev;
    wire dn = GAIN_HALF_DB == gprev - 8'h01;
    wire up = GAIN_HALF_DB == gprev + 8'h01;
    function automatic logic [7:0] inc(input logic [7:0] x);
        return (x == 8'hFF) ? x : x + 8'h01;
    endfunction
    always_ff @(posedge REF_CLK)
    begin
        if (!RESETN)
        begin
            wr_ago <= 8'hFF;
            sd_ago <= 8'hFF;
            sd_lo  <= 8'h00;
            gate_n <= 8'h00;
            over_n <= 8'h00;
            dgap   <= 8'hFF;
            igap   <= 8'hFF;
            gprev  <= 8'h00;
        end
        else
        begin
            wr_ago <= (PSEL && PENABLE && PWRITE) ? 8'h00 : inc(wr_ago);
            sd_ago <= SHUTDOWN_N_PIN ? inc(sd_ago) : 8'h00;
            sd_lo  <= SHUTDOWN_N_PIN ? 8'h00 : inc(sd_lo);
            gate_n <= ENV_UNDER_GATE ? inc(gate_n) : 8'h00;
            over_n <= ENV_OVER_LIMIT ? inc(over_n) : 8'h00;
            dgap   <= dn ? 8'h00 : inc(dgap);
            igap   <= up ? 8'h00 : inc(igap);
            gprev  <= GAIN_HALF_DB;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);
    sequence s_short_held;
        $past(SHORT_DET, 4) && $past(SHORT_DET, 5);
    endsequence
    a_dec_gap: assert property (dn && over_n > 8'h06
        |-> dgap >= TICK_CYC - 1) else $error("decrement too soon");
    a_inc_gap: assert property (up && $past(ENV_UNDER_TARGET, 5)
        |-> igap >= TICK_CYC - 1) else $error("increment too soon");
    a_dec_wins: assert property (
        over_n > 8'h06 && gate_n == 8'h00 && wr_ago > 8'h04
        && $changed(GAIN_HALF_DB) |-> dn)
        else $error("gain change not one step down");
    a_gate_freeze: assert property (gate_n > 8'h06 && wr_ago > 8'h06
        |-> $stable(GAIN_HALF_DB)) else $error("gain moved below gate");
    a_shut_gain: assert property (sd_lo > 8'h08 && wr_ago > 8'h06
        |-> $stable(GAIN_HALF_DB)) else $error("gain moved in shutdown");
    a_duty_rise: assert property ($rose(LOW_DUTY) |-> s_short_held)
        else $error("low duty without short");
    a_duty_exit: assert property ($fell(LOW_DUTY)
        |-> sd_ago < 8'h08 || wr_ago < 8'h04) else $error("duty ended early");
    a_irq_clear: assert property ($fell(IRQ) |-> wr_ago < 8'h03)
        else $error("flag cleared without write");
    a_shut_chan: assert property (sd_lo > 8'h06
        |-> CH_ENABLE == 2'b00) else $error("channel on in shutdown");
endmodule

bind agcf_top agcf_monitor #(.TICK_CYC(TICK_CYC)) u_agcf_monitor (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .SHUTDOWN_N_PIN(SHUTDOWN_N_PIN), .SHORT_DET(SHORT_DET),
    .ENV_OVER_LIMIT(ENV_OVER_LIMIT), .ENV_UNDER_TARGET(ENV_UNDER_TARGET),
    .ENV_UNDER_GATE(ENV_UNDER_GATE), .GAIN_HALF_DB(GAIN_HALF_DB),
    .LOW_DUTY(LOW_DUTY), .CH_ENABLE(CH_ENABLE), .IRQ(IRQ)
);

// ===== agcf_host.sv
// Register bus host model driving APB transfers
module agcf_host (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer: setup, then access until ready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w; // Write when w is set, read otherwise
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge clk);
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench of the gain and fault controller
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 4;
    logic clk, rstn, sd_n, shrt, over, under, gate;
    logic psel, pen, pwr, prdy, perr, ldty, irq;
    logic [7:0] padr, gain, gv;
    logic [31:0] pwd, prd;
    logic [4:0] lim;
    logic [1:0] rat, chen;
    logic [7:0] mdl [10];
    int failures, n_compared;
    agcf_top #(.TICK_CYC(TC)) u_agcf_top (
        .REF_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .SHUTDOWN_N_PIN(sd_n),
        .SHORT_DET(shrt), .ENV_OVER_LIMIT(over), .ENV_UNDER_TARGET(under),
        .ENV_UNDER_GATE(gate), .GAIN_HALF_DB(gain), .LIMIT_LEVEL(lim),
        .COMP_RATIO(rat), .LOW_DUTY(ldty), .CH_ENABLE(chen), .IRQ(irq));
    agcf_host host (.clk(clk), .psel(psel), .penable(pen), .pwrite(pwr),
        .paddr(padr), .pwdata(pwd), .prdata(prd), .pready(prdy),
        .pslverr(perr));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        host.xfer(1'b1, a, {24'h0, d}, q, e);
        mdl[a[7:2]] = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x,
                      output logic e);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q, e);
        `CHK(q, {24'h0, x})
    endtask
    function automatic int eg(int f, int c);
        int lo;
        lo = c ? -28 : 0;
        return 2 * (f < lo ? lo : (f > 30 ? 30 : f));
    endfunction
    task automatic end_sim();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
    initial
    begin : main
        int n, f;
        logic e;
        logic [7:0] rv [9];
        rv = '{agcf_pkg::CTRL_RST, 8'h00, agcf_pkg::MASK_RST,
               agcf_pkg::ATTACK_RST, agcf_pkg::RELEASE_RST, agcf_pkg::HOLD_RST,
               agcf_pkg::FIXED_RST, agcf_pkg::MAXGAIN_RST, agcf_pkg::LIMIT_RST};
        rstn = 1'b0;
        sd_n = 1'b1;
        shrt = 1'b0;
        over = 1'b0;
        under = 1'b0;
        gate = 1'b0;
        void'($urandom(22529));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
            mdl[i] = rv[i];
            rd(8'(4 * i), rv[i], e);
        end
        rd(8'h24, 8'h0C, e);
        rd(8'h28, 8'h00, e);
        `CHK(e, 1'b1)
        `CHK(lim, agcf_pkg::LIMIT_RST[4:0])
        for (int m = 0; m < 2; m++)
        begin
            shrt <= 1'b1;
            repeat (8) @(posedge clk);
            `CHK(ldty, 1'b1)
            shrt <= 1'b0;
            repeat (8) @(posedge clk);
            `CHK(ldty, 1'b1)
            rd(8'h04, 8'h08, e);
            wr(8'h08, 8'h08);
            `CHK(irq, 1'b1)
            wr(8'h04, 8'h08);
            rd(8'h04, 8'h00, e);
            `CHK(irq, 1'b0)
            if (m == 0)
                sd_n <= 1'b0;
            else
                wr(8'h00, 8'h19);
            repeat (12) @(posedge clk);
            `CHK(ldty, 1'b0)
            `CHK(chen, 2'b00)
            sd_n <= 1'b1;
            wr(8'h00, 8'h18);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h00, 8'(8'h18 | (i << 1)));
            repeat (3) @(posedge clk);
            `CHK(chen, ~2'(i))
        end
        wr(8'h00, 8'h18);
        wr(8'h0C, 8'h02);
        wr(8'h10, 8'h03);
        wr(8'h14, 8'h01);
        wr(8'h08, 8'h03);
        over <= 1'b1;
        under <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            gv = gain;
            n = 0;
            while (gain === gv && n < 400)
            begin
                @(posedge clk);
                n++;
            end
            `CHK(gain, gv - 8'h01)
            `CHK(k == 0 || n >= TC, 1'b1)
        end
        `CHK(irq, 1'b1)
        rd(8'h04, 8'h01, e);
        gate <= 1'b1;
        repeat (8) @(posedge clk);
        gv = gain;
        repeat (60) @(posedge clk);
        `CHK(gain, gv)
        over <= 1'b0;
        gate <= 1'b0;
        wr(8'h1C, 8'h05);
        repeat (400) @(posedge clk);
        `CHK(gain, 8'h0A)
        rd(8'h04, 8'h03, e);
        wr(8'h04, 8'h03);
        under <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            f = int'($urandom_range(62)) - 30;
            wr(8'h18, 8'(f));
            wr(8'h00, k[0] ? 8'h50 : 8'h20);
            repeat (3) @(posedge clk);
            `CHK(gain, 8'(eg(f, k[0])))
            `CHK(rat, k[0] ? 2'b10 : 2'b01)
        end
        for (int i = 2; i < 9; i++)
            rd(8'(4 * i), mdl[i], e);
        rd(8'h00, mdl[0], e);
        end_sim();
    end
endmodule
